// ==== dv/hbmd_host_bus_asserts.sv ====
// Checker: port level properties of the host bus front end
`timescale 1ns/1ps
module hbmd_host_bus_asserts
    import hbmd_pkg::*;
#(
    parameter logic [11:0] PORT_BASE     = 12'h300,
    parameter int          SETTLE_CYCLES = HBMD_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // Host side
    input wire logic [9:0] host_addr,
    input wire logic       chip_select_n,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       strap_select_1,
    input wire logic       eeprom_clock_req,
    // Device side
    input wire hbmd_mode_t bus_mode,
    input wire logic       mode_valid,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_read,
    input wire logic       reg_write,
    input wire logic       index_write,
    input wire logic       aux_channel_one,
    input wire logic       databus_direction,
    input wire logic       data_drive_oe_n,
    input wire logic       eeprom_serial_clock,
    input wire logic       eeprom_serial_data_in
);
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
wire isa_ok = mode_valid && bus_mode == HBMD_MODE_ISA;
wire eep_ok = mode_valid && bus_mode inside {HBMD_MODE_PNP, HBMD_MODE_CARD};
////////////////////////////////////////////////////////////////////////////////
a_mode_held:
    assert property (mode_valid && $past(mode_valid) |-> $stable(bus_mode))
    else $error("bus mode changed while valid");
a_isa_data_read:
    assert property (isa_ok && $past(isa_ok, 3) && $past(host_addr, 3) == PORT_BASE[9:0]
        && !$past(read_strobe_n, 3) |-> reg_read && !databus_direction && !data_drive_oe_n)
    else $error("data port read not decoded");
a_isa_index_write:
    assert property (isa_ok && $past(isa_ok, 3) && !$past(write_strobe_n, 3)
        && $past(host_addr, 3) == {PORT_BASE[9:1], 1'b1} |-> index_write && !reg_write)
    else $error("index port write not decoded");
a_isa_outside:
    assert property (isa_ok && $past(isa_ok, 3) && $past(host_addr[9:1], 3) != PORT_BASE[9:1]
        |-> !reg_read && !reg_write && !index_write)
    else $error("access outside port base decoded");
a_proc_direct:
    assert property (mode_valid && bus_mode == HBMD_MODE_SEP && $past(mode_valid, 3)
        && $past(host_addr[9:8], 3) == 2'h3 && !$past(chip_select_n, 3)
        && !$past(read_strobe_n, 3) && $past(write_strobe_n, 3)
        |-> reg_read && reg_addr == {$past(host_addr[7], 3), 1'b0, $past(host_addr[5:0], 3)})
    else $error("direct register read wrong");
a_ack_invert:
    assert property (mode_valid && bus_mode inside {HBMD_MODE_SEP, HBMD_MODE_MUX}
        && $past(mode_valid, 3) && !$past(host_addr[8], 3) && !$past(read_strobe_n, 3)
        |-> aux_channel_one && reg_write && !reg_read)
    else $error("acknowledged read not turned into write");
a_card_direction:
    assert property (mode_valid && bus_mode == HBMD_MODE_CARD |-> databus_direction)
    else $error("direction low in card mode");
a_eeprom_clock:
    assert property (eep_ok && $rose(eeprom_clock_req) |-> ##[1:3] eeprom_serial_clock)
    else $error("serial clock not driven");
a_eeprom_data_in:
    assert property (eep_ok && $rose(strap_select_1) |-> ##[1:4] eeprom_serial_data_in)
    else $error("serial data not received");
c_isa_read: cover property (isa_ok && reg_read);
c_ack_one: cover property (aux_channel_one && reg_write);
c_mux_mode: cover property (mode_valid && bus_mode == HBMD_MODE_MUX);
endmodule
bind hbmd_host_bus hbmd_host_bus_asserts #(.PORT_BASE(PORT_BASE), .SETTLE_CYCLES(SETTLE_CYCLES))
    chk_u (.*);

// ==== dv/hbmd_host_bus_tb_top.sv ====
// Testbench: strap decode, port decode and pin remapping scenarios
`timescale 1ns/1ps
module hbmd_host_bus_tb_top
    import hbmd_pkg::*;
;
logic ref_clk, reset, mode_pin_open, mode_pin_high, ee_far;
logic strap_select_0, strap_select_2, strap_select_3;
logic eeprom_clock_req, eeprom_data_req, eeprom_data_oe_req;
logic [9:0] host_addr;
logic chip_select_n, read_strobe_n, write_strobe_n, data_strobe_n, read_not_write, addr_latch;
logic [7:0] host_data_in, reg_addr;
logic eeprom_serial_clock, eeprom_serial_data_out, eeprom_serial_data_oe_n;
logic eeprom_serial_data_in, mode_valid, reg_read, reg_write, index_write;
logic aux_channel_one, aux_channel_two, databus_direction, data_drive_oe_n;
hbmd_mode_t bus_mode;
int fail_count = 0;
int num_checks = 0;
// Pull-up side of the shared serial data pin
wire strap_select_1 = eeprom_serial_data_oe_n ? ee_far : eeprom_serial_data_out;
hbmd_host_bus #(.SETTLE_CYCLES(4)) dut_u (.*);
hbmd_host_model host_u (.*);
initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
end
////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
        fail_count++;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask
// Latch must toggle after release so the settle window sees a falling edge
task automatic boot(input logic [3:0] sel, input logic op, hi, al, pl);
    int n = 0;
    @(posedge ref_clk);
    reset <= 1'b1;
    {strap_select_3, strap_select_2, ee_far, strap_select_0} <= sel;
    mode_pin_open <= op;
    mode_pin_high <= hi;
    host_u.addr_latch <= al;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    while (mode_valid !== 1'b1) begin
        @(posedge ref_clk);
        if (pl) host_u.addr_latch <= !host_u.addr_latch;
        n++;
        if (n > 200) begin
            fail_count++;
            $display("mismatch at %0t: mode never valid", $time);
            summarize();
        end
    end
    host_u.addr_latch <= al;
    repeat (4) @(posedge ref_clk);
endtask
task automatic acc(input logic [9:0] a, input logic rd, input logic [7:0] d);
    host_u.stop();
    host_u.start(a, rd, d);
    repeat (4) @(posedge ref_clk);
    #1;
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_modes();
    logic [10:0] tbl [8] = '{11'h2c1, 11'h052, 11'h043, 11'h04c,
                             11'h505, 11'h005, 11'h026, 11'h2d0};
    for (int i = 0; i < 8; i++) begin
        boot(tbl[i][10:7], tbl[i][6], tbl[i][5], tbl[i][4], tbl[i][3]);
        check({9'h0, bus_mode}, {9'h0, tbl[i][2:0]});
        {strap_select_3, strap_select_2, strap_select_0} <=
            ~{strap_select_3, strap_select_2, strap_select_0};
        mode_pin_open <= !mode_pin_open;
        repeat (8) @(posedge ref_clk);
        check({9'h0, bus_mode}, {9'h0, tbl[i][2:0]});
    end
    $display("test modes done");
endtask
task automatic t_isa();
    boot(4'hf, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(10'h301, 1'b0, 8'h5a);
    check({11'h0, index_write}, 12'h1);
    acc(10'h300, 1'b0, 8'h11);
    check({3'h0, reg_write, reg_addr}, 12'h15a);
    acc(10'h300, 1'b1, 8'h00);
    check({9'h0, reg_read, databus_direction, data_drive_oe_n}, 12'h4);
    acc(10'h100, 1'b1, 8'h00);
    check({9'h0, reg_read, reg_write, index_write}, 12'h0);
    acc(10'h302, 1'b0, 8'h00);
    check({9'h0, reg_read, reg_write, index_write}, 12'h0);
    $display("test isa done");
endtask
task automatic t_pnp();
    // Serial data pin rests high through its pull-up when nobody drives it
    boot(4'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    strap_select_2 <= 1'b1;
    acc(10'h300, 1'b1, 8'h00);
    check({11'h0, reg_read}, 12'h0);
    strap_select_2 <= 1'b0;
    acc(10'h300, 1'b1, 8'h00);
    check({10'h0, reg_read, databus_direction}, 12'h2);
    eeprom_clock_req <= 1'b1;
    eeprom_data_oe_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check({8'h0, eeprom_serial_clock, eeprom_serial_data_oe_n, eeprom_serial_data_out,
        eeprom_serial_data_in}, 12'h8);
    @(posedge ref_clk);
    eeprom_clock_req <= 1'b0;
    eeprom_data_oe_req <= 1'b0;
    eeprom_data_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check({8'h0, eeprom_serial_clock, eeprom_serial_data_oe_n, eeprom_serial_data_out,
        eeprom_serial_data_in}, 12'h7);
    $display("test pnp done");
endtask
task automatic t_proc();
    boot(4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(10'h3b5, 1'b1, 8'h00);
    check({3'h0, reg_read, reg_addr}, 12'h1b5);
    acc(10'h2b5, 1'b1, 8'h00);
    check({9'h0, aux_channel_one, reg_write, reg_read}, 12'h6);
    acc(10'h1b5, 1'b0, 8'h00);
    check({9'h0, aux_channel_two, reg_read, reg_write}, 12'h6);
    boot(4'h0, 1'b1, 1'b0, 1'b1, 1'b0);
    acc(10'h3a3, 1'b1, 8'h00);
    check({3'h0, reg_read, reg_addr}, 12'h1a3);
    acc(10'h3a3, 1'b0, 8'h00);
    check({11'h0, reg_write}, 12'h1);
    $display("test processor done");
endtask
task automatic t_mux();
    boot(4'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    host_u.latch(8'h93);
    acc(10'h324, 1'b1, 8'h24);
    check({3'h0, reg_read, reg_addr}, 12'h193);
    host_u.latch(8'h2c);
    acc(10'h324, 1'b1, 8'h24);
    check({3'h0, reg_read, reg_addr}, 12'h12c);
    $display("test mux done");
endtask
initial begin
    reset = 1'b1;
    mode_pin_open = 1'b1;
    mode_pin_high = 1'b0;
    ee_far = 1'b1;
    {strap_select_0, strap_select_2, strap_select_3} = 3'h7;
    {eeprom_clock_req, eeprom_data_req, eeprom_data_oe_req} = 3'h0;
    t_modes();
    t_isa();
    t_pnp();
    t_proc();
    t_mux();
    summarize();
end
endmodule

// ==== dv/hbmd_host_model.sv ====
// Host bus master model: address, strobes, data lines and address latch pin
`timescale 1ns/1ps
module hbmd_host_model (
    // Clock
    input  wire logic ref_clk,
    // Host bus
    output logic [9:0] host_addr,
    output logic       chip_select_n,
    output logic       read_strobe_n,
    output logic       write_strobe_n,
    output logic       data_strobe_n,
    output logic       read_not_write,
    output logic [7:0] host_data_in,
    output logic       addr_latch
);
initial begin
    host_addr = 10'h3ff;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    data_strobe_n = 1'b1;
    read_not_write = 1'b1;
    host_data_in = 8'h00;
    addr_latch = 1'b0;
end
task automatic start(input logic [9:0] a, input logic rd, input logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_data_in <= d;
    chip_select_n <= 1'b0;
    read_strobe_n <= !rd;
    write_strobe_n <= rd;
    data_strobe_n <= 1'b0;
    read_not_write <= rd;
endtask
task automatic stop();
    @(posedge ref_clk);
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    data_strobe_n <= 1'b1;
    host_addr <= ~host_addr & 10'h3bf;
    host_data_in <= ~host_data_in;
endtask
task automatic latch(input logic [7:0] a);
    @(posedge ref_clk);
    host_data_in <= a & 8'hbf;
    host_addr <= {2'h3, a & 8'hbf};
    addr_latch <= 1'b1;
    repeat (2) @(posedge ref_clk);
    addr_latch <= 1'b0;
endtask
endmodule

// ==== hw/hbmd_host_bus.sv ====
// Host bus front end: strap mode decode, index/data port decode and pin remapping
`timescale 1ns/1ps
// Operation
// RULE1: Open mode, low latch, straps nonzero: ISA
// RULE2: Zero straps, latch high: strobe bus mode
// RULE3: Zero straps, latch low: separate buses mode
// RULE4: Latch pulses: multiplexed, address captured each pulse
// RULE5: Board wires address to data, line six grounded
// RULE6: Mode and latch grounded: plug-and-play mode
// RULE7: Latch grounded, mode high: card mode
// RULE8: Port modes: bit0 high index, low data
// RULE9: Base from ten or twelve address lines
// RULE10: System grounds address line six in processor modes
// RULE11: Processor modes: direct register select, skip six
// RULE12: Select straps pulled up, pick mode, address
// RULE13: Port modes five, six: EEPROM and high address
// RULE14: Processor modes: address eight, nine are acks
// RULE15: Ack active: strobes inverted, address ignored
// RULE16: Direction low while driving data lines (code holds direction high in card mode)
// RULE17: Straps sampled at reset, mode held
module hbmd_host_bus
    import hbmd_pkg::*;
#(
    parameter logic [11:0] PORT_BASE       = 12'h300,
    parameter int          SETTLE_CYCLES   = HBMD_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Strap pins
    input  wire logic             mode_pin_open,
    input  wire logic             mode_pin_high,
    input  wire logic             addr_latch,
    input  wire logic             strap_select_0,
    input  wire logic             strap_select_1,
    input  wire logic             strap_select_2,
    input  wire logic             strap_select_3,
    // Host address and strobes
    input  wire logic [9:0]       host_addr,
    input  wire logic             chip_select_n,
    input  wire logic             read_strobe_n,
    input  wire logic             write_strobe_n,
    input  wire logic             data_strobe_n,
    input  wire logic             read_not_write,
    input  wire logic [7:0]       host_data_in,
    // EEPROM lines
    input  wire logic             eeprom_clock_req,
    input  wire logic             eeprom_data_req,
    input  wire logic             eeprom_data_oe_req,
    output logic                  eeprom_serial_clock,
    output logic                  eeprom_serial_data_out,
    output logic                  eeprom_serial_data_oe_n,
    output logic                  eeprom_serial_data_in,
    // Decoded bus mode and access
    output hbmd_mode_t            bus_mode,
    output logic                  mode_valid,
    output logic [7:0]            reg_addr,
    output logic                  reg_read,
    output logic                  reg_write,
    output logic                  index_write,
    output logic                  aux_channel_one,
    output logic                  aux_channel_two,
    output logic                  databus_direction,
    output logic                  data_drive_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int PIN_W = 30;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;

    assign pins_raw = {host_data_in, read_not_write, data_strobe_n,
                       write_strobe_n, read_strobe_n, chip_select_n, host_addr,
                       strap_select_3, strap_select_2, strap_select_1, strap_select_0,
                       addr_latch, mode_pin_high, mode_pin_open};

    hbmd_sync #(.WIDTH (PIN_W)) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .pin_in   (pins_raw),
        .pin_sync (pins_s)
    );

    logic       s_mode_open;
    logic       s_mode_high;
    logic       s_latch;
    logic [3:0] s_sel;
    logic [9:0] s_addr;
    logic       s_cs_n;
    logic       s_rd_n;
    logic       s_wr_n;
    logic       s_ds_n;
    logic       s_rnw;
    logic [7:0] s_data;

    assign s_mode_open = pins_s[0];
    assign s_mode_high = pins_s[1];
    assign s_latch     = pins_s[2];
    assign s_sel       = pins_s[6:3];
    assign s_addr      = pins_s[16:7];
    assign s_cs_n      = pins_s[17];
    assign s_rd_n      = pins_s[18];
    assign s_wr_n      = pins_s[19];
    assign s_ds_n      = pins_s[20];
    assign s_rnw       = pins_s[21];
    assign s_data      = pins_s[29:22];

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture

    hbmd_state_t state_reg, state_next;
    hbmd_mode_t  mode_reg, mode_next, mode_dec;
    logic [15:0] settle_reg, settle_next;
    logic        latch_d_reg, latch_d_next;
    logic        pulse_seen_reg, pulse_seen_next;
    logic        latch_high_reg, latch_high_next;
    logic        valid_reg, valid_next;

    hbmd_mode_decode u_dec (
        .mode_open    (s_mode_open),
        .mode_high    (s_mode_high),
        .latch_high   (latch_high_reg),
        .latch_pulsed (pulse_seen_reg),
        .strap_select (s_sel),
        .mode         (mode_dec)
    );

    // RULE17 sample then hold
    always_comb begin
        state_next      = state_reg;
        mode_next       = mode_reg;
        settle_next     = settle_reg;
        latch_d_next    = s_latch;
        pulse_seen_next = pulse_seen_reg;
        latch_high_next = latch_high_reg;
        valid_next      = valid_reg;
        case (state_reg)
            HBMD_ST_SYNC: begin
                settle_next = 16'h0000;
                state_next  = HBMD_ST_SAMPLE;
            end
            HBMD_ST_SAMPLE: begin
                // A falling edge seen during the window marks a pulsed latch
                if (latch_d_reg && !s_latch)
                    pulse_seen_next = 1'b1;
                latch_high_next = s_latch & ~pulse_seen_reg;
                settle_next     = settle_reg + 16'h0001;
                if (settle_reg >= 16'(SETTLE_CYCLES)) begin
                    mode_next  = mode_dec;
                    valid_next = 1'b1;
                    state_next = HBMD_ST_RUN;
                end
            end
            default: begin
                state_next = HBMD_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg      <= HBMD_ST_SYNC;
            mode_reg       <= HBMD_MODE_NONE;
            settle_reg     <= 16'h0000;
            latch_d_reg    <= 1'b0;
            pulse_seen_reg <= 1'b0;
            latch_high_reg <= 1'b0;
            valid_reg      <= 1'b0;
        end else begin
            state_reg      <= state_next;
            mode_reg       <= mode_next;
            settle_reg     <= settle_next;
            latch_d_reg    <= latch_d_next;
            pulse_seen_reg <= pulse_seen_next;
            latch_high_reg <= latch_high_next;
            valid_reg      <= valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode

    logic port_mode;
    logic proc_mode;
    logic [11:0] full_addr;
    logic base_hit;
    logic rd_cyc;
    logic wr_cyc;
    logic ack_one;
    logic ack_two;
    logic [7:0] mux_addr_reg, mux_addr_next;
    logic [7:0] index_reg, index_next;
    logic [7:0] raddr_next, raddr_reg;
    logic rd_next, wr_next, iw_next, a1_next, a2_next, dir_next, oe_next;
    logic rd_reg, wr_reg, iw_reg, a1_reg, a2_reg, dir_reg, oe_reg;
    logic sck_next, sda_next, sdaoe_next, sck_reg, sda_reg, sdaoe_reg, sdain_reg;

    assign port_mode = valid_reg && (mode_reg == HBMD_MODE_ISA || mode_reg == HBMD_MODE_PNP
                                  || mode_reg == HBMD_MODE_CARD);
    assign proc_mode = valid_reg && (mode_reg == HBMD_MODE_CSRW || mode_reg == HBMD_MODE_SEP
                                  || mode_reg == HBMD_MODE_MUX);

    // RULE13 straps two, three become address bits
    assign full_addr = (mode_reg == HBMD_MODE_ISA) ? {2'b00, s_addr} : {s_sel[3:2], s_addr};

    // RULE9 base compare width per mode
    always_comb begin
        if (mode_reg == HBMD_MODE_ISA)
            base_hit = (s_addr[HBMD_ISA_ADDR_W-1:1] == PORT_BASE[HBMD_ISA_ADDR_W-1:1]);
        else
            base_hit = (full_addr[HBMD_PNP_ADDR_W-1:1] == PORT_BASE[HBMD_PNP_ADDR_W-1:1]);
    end

    // Mode 2 uses a data strobe with a direction line; others separate strobes
    always_comb begin
        if (mode_reg == HBMD_MODE_CSRW) begin
            rd_cyc = !s_cs_n && !s_ds_n && s_rnw;
            wr_cyc = !s_cs_n && !s_ds_n && !s_rnw;
        end else if (proc_mode) begin
            rd_cyc = !s_cs_n && !s_rd_n;
            wr_cyc = !s_cs_n && !s_wr_n;
        end else begin
            rd_cyc = !s_rd_n;
            wr_cyc = !s_wr_n;
        end
    end

    // RULE14 address eight and nine as acks
    assign ack_one = proc_mode && !s_addr[8];
    assign ack_two = proc_mode && !s_addr[9];

    always_comb begin
        mux_addr_next = mux_addr_reg;
        index_next    = index_reg;
        raddr_next    = raddr_reg;
        rd_next = 1'b0;
        wr_next = 1'b0;
        iw_next = 1'b0;
        a1_next = 1'b0;
        a2_next = 1'b0;
        // RULE4 capture address on latch
        // RULE5 address arrives on data lines
        if (mode_reg == HBMD_MODE_MUX && valid_reg && s_latch)
            mux_addr_next = s_data;
        if (ack_one || ack_two) begin
            // RULE15 inverted strobes, address ignored
            a1_next    = ack_one;
            a2_next    = ack_two & ~ack_one;
            rd_next    = wr_cyc;
            wr_next    = rd_cyc;
        end else if (proc_mode) begin
            // RULE11 direct select, line six skipped
            // RULE10 line six assumed grounded
            raddr_next = (mode_reg == HBMD_MODE_MUX) ? mux_addr_reg : s_addr[7:0];
            raddr_next[HBMD_GROUND_BIT] = 1'b0;
            rd_next = rd_cyc;
            wr_next = wr_cyc;
        end else if (port_mode && base_hit) begin
            // RULE8 index port versus data port
            raddr_next = index_reg;
            if (s_addr[HBMD_INDEX_BIT]) begin
                if (wr_cyc) begin
                    index_next = s_data;
                    iw_next    = 1'b1;
                end
            end else begin
                rd_next    = rd_cyc;
                wr_next    = wr_cyc;
            end
        end
        // RULE16 direction low while driving, except held high in card mode
        oe_next  = ~rd_next;
        dir_next = (mode_reg == HBMD_MODE_CARD) ? 1'b1 : ~rd_next;
        // RULE13 EEPROM clock and data on straps
        // RULE12 straps stay pulled-up inputs otherwise
        if (valid_reg && (mode_reg == HBMD_MODE_PNP || mode_reg == HBMD_MODE_CARD)) begin
            sck_next   = eeprom_clock_req;
            sda_next   = eeprom_data_req;
            sdaoe_next = ~eeprom_data_oe_req;
        end else begin
            sck_next   = 1'b0;
            sda_next   = 1'b0;
            sdaoe_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mux_addr_reg <= 8'h00;
            index_reg    <= HBMD_INDEX_RESET;
            raddr_reg    <= 8'h00;
            rd_reg       <= 1'b0;
            wr_reg       <= 1'b0;
            iw_reg       <= 1'b0;
            a1_reg       <= 1'b0;
            a2_reg       <= 1'b0;
            dir_reg      <= 1'b1;
            oe_reg       <= 1'b1;
            sck_reg      <= 1'b0;
            sda_reg      <= 1'b0;
            sdaoe_reg    <= 1'b1;
            sdain_reg    <= 1'b0;
        end else begin
            mux_addr_reg <= mux_addr_next;
            index_reg    <= index_next;
            raddr_reg    <= raddr_next;
            rd_reg       <= rd_next;
            wr_reg       <= wr_next;
            iw_reg       <= iw_next;
            a1_reg       <= a1_next;
            a2_reg       <= a2_next;
            dir_reg      <= dir_next;
            oe_reg       <= oe_next;
            sck_reg      <= sck_next;
            sda_reg      <= sda_next;
            sdaoe_reg    <= sdaoe_next;
            sdain_reg    <= s_sel[1];
        end
    end

    assign bus_mode                = mode_reg;
    assign mode_valid              = valid_reg;
    assign reg_addr                = raddr_reg;
    assign reg_read                = rd_reg;
    assign reg_write               = wr_reg;
    assign index_write             = iw_reg;
    assign aux_channel_one         = a1_reg;
    assign aux_channel_two         = a2_reg;
    assign databus_direction       = dir_reg;
    assign data_drive_oe_n         = oe_reg;
    assign eeprom_serial_clock     = sck_reg;
    assign eeprom_serial_data_out  = sda_reg;
    assign eeprom_serial_data_oe_n = sdaoe_reg;
    assign eeprom_serial_data_in   = sdain_reg;

endmodule

// ==== hw/hbmd_mode_decode.sv ====
// Combinational strap pattern to bus mode decode
`timescale 1ns/1ps
module hbmd_mode_decode
    import hbmd_pkg::*;
(
    // Straps (synchronised)
    input  wire logic       mode_open,
    input  wire logic       mode_high,
    input  wire logic       latch_high,
    input  wire logic       latch_pulsed,
    input  wire logic [3:0] strap_select,
    // Result
    output hbmd_mode_t      mode
);

    always_comb begin
        mode = HBMD_MODE_NONE;
        if (mode_open) begin
            if (strap_select != HBMD_SEL_ALL_ZERO) begin
                // RULE1 ISA port mode
                if (!latch_high && !latch_pulsed)
                    mode = HBMD_MODE_ISA;
            end else if (latch_pulsed) begin
                // RULE4 multiplexed mode
                mode = HBMD_MODE_MUX;
            end else if (latch_high) begin
                // RULE2 strobe bus mode
                mode = HBMD_MODE_CSRW;
            end else begin
                // RULE3 separate buses mode
                mode = HBMD_MODE_SEP;
            end
        end else if (!latch_high && !latch_pulsed) begin
            // RULE6 plug-and-play mode
            // RULE7 card mode
            mode = mode_high ? HBMD_MODE_CARD : HBMD_MODE_PNP;
        end
    end

endmodule

// ==== hw/hbmd_sync.sv ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module hbmd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Data
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign pin_sync = sync_reg;

endmodule

// ==== inc/hbmd_pkg.sv ====
// Package: bus mode encodings, strap patterns and decode constants for the host bus front end
package hbmd_pkg;

    // Bus modes after strap decode
    typedef enum logic [2:0] {
        HBMD_MODE_NONE = 3'h0,
        HBMD_MODE_ISA  = 3'h1,
        HBMD_MODE_CSRW = 3'h2,
        HBMD_MODE_SEP  = 3'h3,
        HBMD_MODE_MUX  = 3'h4,
        HBMD_MODE_PNP  = 3'h5,
        HBMD_MODE_CARD = 3'h6
    } hbmd_mode_t;

    // Strap capture sequencing
    typedef enum logic [1:0] {
        HBMD_ST_SYNC   = 2'h0,
        HBMD_ST_SAMPLE = 2'h1,
        HBMD_ST_RUN    = 2'h3
    } hbmd_state_t;

    localparam logic [3:0] HBMD_SEL_ALL_ZERO   = 4'h0;
    localparam int         HBMD_ISA_ADDR_W     = 10;
    localparam int         HBMD_PNP_ADDR_W     = 12;
    localparam int         HBMD_REG_ADDR_W     = 8;
    localparam int         HBMD_INDEX_BIT      = 0;
    localparam int         HBMD_GROUND_BIT     = 6;
    localparam logic [7:0] HBMD_INDEX_RESET    = 8'h00;
    // Cycles spent watching the address latch pin for pulses before the mode is frozen
    localparam int         HBMD_SETTLE_NS      = 64;
    localparam int         HBMD_CLK_PERIOD_NS  = 4;
    localparam int         HBMD_SETTLE_CYCLES  = HBMD_SETTLE_NS / HBMD_CLK_PERIOD_NS;
    localparam int         HBMD_SYNC_STAGES    = 2;

endpackage
